//--- include/acc_map.svh
// Register map, field positions and reset values of the comparator control block.
// Assumes inclusion by bare name from the design files.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ACC_OFF_CTRL 12'h000
`define ACC_OFF_IRQ_STATUS 12'h004
`define ACC_OFF_IRQ_MASK 12'h008

// ----------------------------------------------------------------------------
// Field positions of the status and control register
// ----------------------------------------------------------------------------
`define ACC_BIT_ENABLE 7
`define ACC_BIT_REF_SEL 6
`define ACC_BIT_FLAG 5
`define ACC_BIT_IRQ_EN 4
`define ACC_BIT_LEVEL 3
`define ACC_BIT_PIN_EN 2
`define ACC_MODE_HI 1
`define ACC_MODE_LO 0

// ----------------------------------------------------------------------------
// Interrupt status bit positions and reset values
// ----------------------------------------------------------------------------
`define ACC_IRQ_BIT_EVENT 0
`define ACC_CTRL_RESET 8'h00
`define ACC_IRQ_RESET 1'h0
`define ACC_ZERO_WORD 32'h0000_0000

`endif

//--- include/acc_pkg.sv
// Types shared by the comparator control block.
// Assumes nothing of its surroundings.
package acc_pkg;

   // --------------------------------------------------------------------------
   // Edge mode codes
   // --------------------------------------------------------------------------
   typedef enum logic [1:0] {
      ACC_MODE_FALL0 = 2'h0,
      ACC_MODE_RISE = 2'h1,
      ACC_MODE_FALL2 = 2'h2,
      ACC_MODE_BOTH = 2'h3
   } acc_mode_t;

endpackage

//--- rtl/acc_sync.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/100ps

module acc_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Level
   input wire logic async_in,
   output logic sync_out
);

   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;

   always_comb begin
      meta_next = meta_reg;
      sync_next = sync_reg;
      if (clk_en) begin
         meta_next = async_in;
         sync_next = meta_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;

endmodule

//--- rtl/acc_top.sv
// Control and status logic around an analog voltage comparator, APB slave.
// Assumes the analog comparator sits outside and hands back an async level,
// and that a system reset is applied on exit from powered-down stop states.
// Register map: status and control byte at 0x000, sticky event status at
// 0x004 and its mask at 0x008; only byte lane 0 is decoded.
// Assumes clk_en stays high for the whole of an APB transfer.
`timescale 1ns/100ps

`include "acc_map.svh"

module acc_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog comparator controls and result
   output logic comp_power_en,
   output logic reference_select,
   input wire logic comp_out_async,
   // Output pin
   output logic compare_out_pin,
   output logic compare_out_pin_oe,
   // Interrupt and wake
   output logic irq,
   output logic wake_req
);

   // --------------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------------
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic irq_stat_reg;
   logic irq_stat_next;
   logic irq_mask_reg;
   logic irq_mask_next;
   logic prev_level_reg;
   logic prev_level_next;
   logic pin_reg;
   logic pin_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // Decode, datapath and field views
   logic level_sync;
   logic level;
   logic rise;
   logic fall;
   logic event_hit;
   logic acc_wr;
   logic acc_rd;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_mask;
   logic lane0_wr;
   logic [7:0] ctrl_view;
   acc_pkg::acc_mode_t mode;
   logic en_bit;
   logic ref_bit;
   logic flag_bit;
   logic ie_bit;
   logic pin_en_bit;
   logic ctrl_wr;
   logic stat_clr;
   logic mask_wr;
   logic native_req;
   logic stat_req;
   logic [31:0] rd_word;

   // --------------------------------------------------------------------------
   // Comparator result path
   // --------------------------------------------------------------------------
   // The analog block resolves the input comparison itself; we only see a level.
   acc_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .async_in(comp_out_async),
      .sync_out(level_sync)
   );

   // --------------------------------------------------------------------------
   // Edge detection
   // --------------------------------------------------------------------------
   // Gating with enable keeps the level at zero while the analog side is off
   assign level = level_sync & ctrl_reg[`ACC_BIT_ENABLE];
   assign mode = acc_pkg::acc_mode_t'(ctrl_reg[`ACC_MODE_HI:`ACC_MODE_LO]);

   // Compare with the previous sample of the gated, synchronised level
   always_comb begin
      rise = 1'b0;
      fall = 1'b0;
      if (level != prev_level_reg) begin
         rise = level;
         fall = prev_level_reg;
      end
   end

   always_comb begin
      event_hit = 1'b0;
      // Two codes share the falling-edge meaning
      unique case (mode)
         acc_pkg::ACC_MODE_FALL0: event_hit = fall;
         acc_pkg::ACC_MODE_RISE: event_hit = rise;
         acc_pkg::ACC_MODE_FALL2: event_hit = fall;
         acc_pkg::ACC_MODE_BOTH: event_hit = rise | fall;
      endcase
      // Disabling the module can make an apparent falling edge; only count while on
      event_hit = event_hit & ctrl_reg[`ACC_BIT_ENABLE];
   end

   // --------------------------------------------------------------------------
   // Bus decode
   // --------------------------------------------------------------------------
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign acc_wr = psel & penable & pwrite;
   assign acc_rd = psel & ~penable & ~pwrite;
   assign hit_ctrl = (paddr == `ACC_OFF_CTRL);
   assign hit_stat = (paddr == `ACC_OFF_IRQ_STATUS);
   assign hit_mask = (paddr == `ACC_OFF_IRQ_MASK);
   assign lane0_wr = acc_wr & pstrb[0];
   // Unmapped offsets answer with an error and change nothing
   assign pslverr = psel & penable & ~(hit_ctrl | hit_stat | hit_mask);

   // Software sees the live level in place of the unstored bit
   always_comb begin
      ctrl_view = ctrl_reg;
      ctrl_view[`ACC_BIT_LEVEL] = level;
   end

   // --------------------------------------------------------------------------
   // Field views
   // --------------------------------------------------------------------------
   // Named views of the stored control fields
   assign en_bit = ctrl_reg[`ACC_BIT_ENABLE];
   assign ref_bit = ctrl_reg[`ACC_BIT_REF_SEL];
   assign flag_bit = ctrl_reg[`ACC_BIT_FLAG];
   assign ie_bit = ctrl_reg[`ACC_BIT_IRQ_EN];
   assign pin_en_bit = ctrl_reg[`ACC_BIT_PIN_EN];

   // --------------------------------------------------------------------------
   // Control register
   // --------------------------------------------------------------------------
   // Only byte lane 0 carries fields; a write with it masked is dropped
   assign ctrl_wr = clk_en & lane0_wr & hit_ctrl;

   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         ctrl_next[`ACC_BIT_ENABLE] = pwdata[`ACC_BIT_ENABLE];
         ctrl_next[`ACC_BIT_REF_SEL] = pwdata[`ACC_BIT_REF_SEL];
         ctrl_next[`ACC_BIT_IRQ_EN] = pwdata[`ACC_BIT_IRQ_EN];
         ctrl_next[`ACC_BIT_PIN_EN] = pwdata[`ACC_BIT_PIN_EN];
         ctrl_next[`ACC_MODE_HI:`ACC_MODE_LO] = pwdata[`ACC_MODE_HI:`ACC_MODE_LO];
         // Write one clears; writing zero leaves the flag alone
         if (pwdata[`ACC_BIT_FLAG]) begin
            ctrl_next[`ACC_BIT_FLAG] = 1'b0;
         end
      end
      // Set beats a same-cycle clear so no event is lost
      if (clk_en && event_hit) begin
         ctrl_next[`ACC_BIT_FLAG] = 1'b1;
      end
      // The level bit is never stored; it is always read live
      ctrl_next[`ACC_BIT_LEVEL] = 1'b0;
   end

   // Powered-down stop exits arrive as a system reset, which clears everything
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= `ACC_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // --------------------------------------------------------------------------
   // Interrupt status and mask
   // --------------------------------------------------------------------------
   // Second interrupt path: a sticky copy of every event behind its own mask
   assign stat_clr = clk_en & lane0_wr & hit_stat & pwdata[`ACC_IRQ_BIT_EVENT];
   assign mask_wr = clk_en & lane0_wr & hit_mask;

   always_comb begin
      irq_stat_next = irq_stat_reg;
      irq_mask_next = irq_mask_reg;
      if (stat_clr) begin
         irq_stat_next = 1'b0;
      end
      if (mask_wr) begin
         irq_mask_next = pwdata[`ACC_IRQ_BIT_EVENT];
      end
      // Same priority as the flag: an event in the clearing cycle survives
      if (clk_en && event_hit) begin
         irq_stat_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_reg <= `ACC_IRQ_RESET;
         irq_mask_reg <= `ACC_IRQ_RESET;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // --------------------------------------------------------------------------
   // Edge history and output pin
   // --------------------------------------------------------------------------
   // History follows the gated level so a disabled block shows no edges
   always_comb begin
      prev_level_next = prev_level_reg;
      pin_next = pin_reg;
      if (clk_en) begin
         prev_level_next = level;
         // Enables taken from the next state keep pin and output enable in step
         pin_next = level_sync & ctrl_next[`ACC_BIT_ENABLE] & ctrl_next[`ACC_BIT_PIN_EN];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_level_reg <= 1'b0;
         pin_reg <= 1'b0;
      end else begin
         prev_level_reg <= prev_level_next;
         pin_reg <= pin_next;
      end
   end

   // --------------------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------------------
   // Unmapped offsets read as zero
   always_comb begin
      rd_word = `ACC_ZERO_WORD;
      if (hit_ctrl) begin
         rd_word[`ACC_BIT_ENABLE:`ACC_MODE_LO] = ctrl_view;
      end else if (hit_stat) begin
         rd_word[`ACC_IRQ_BIT_EVENT] = irq_stat_reg;
      end else if (hit_mask) begin
         rd_word[`ACC_IRQ_BIT_EVENT] = irq_mask_reg;
      end
   end

   // Captured in the setup cycle so prdata is already steady in the access phase
   always_comb begin
      rdata_next = rdata_reg;
      if (clk_en && acc_rd) begin
         rdata_next = rd_word;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= `ACC_ZERO_WORD;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // --------------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------------
   assign prdata = rdata_reg;
   assign comp_power_en = en_bit;
   assign reference_select = ref_bit;
   assign compare_out_pin = pin_reg;
   // Pin enable doubles as the pin's output enable
   assign compare_out_pin_oe = pin_en_bit;
   assign native_req = flag_bit & ie_bit;
   assign stat_req = irq_stat_reg & irq_mask_reg;
   // Native request plus the masked sticky-status path share one output
   assign irq = native_req | stat_req;
   // Wake needs no clock of its own; it is a level the power controller watches
   assign wake_req = native_req;

endmodule

//--- verif/acc_top_asserts.sv
// Port-level checker for the comparator control block.
// Assumes binding to acc_top, single clock domain.
`timescale 1ns/100ps

module acc_top_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Comparator, pin and interrupt
   input wire logic comp_power_en,
   input wire logic reference_select,
   input wire logic comp_out_async,
   input wire logic compare_out_pin,
   input wire logic compare_out_pin_oe,
   input wire logic irq,
   input wire logic wake_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic wr;
   assign wr = psel && penable && pwrite && clk_en && pstrb[0] && paddr == 12'h000;
   AST_EN_WR: assert property (wr |=> comp_power_en == $past(pwdata[7])) else $error("enable");
   AST_REF_WR: assert property (wr |=> reference_select == $past(pwdata[6])) else $error("ref");
   AST_OE_WR: assert property (wr |=> compare_out_pin_oe == $past(pwdata[2])) else $error("oe");
   AST_PIN_OFF: assert property (!compare_out_pin_oe |-> !compare_out_pin) else $error("pin");
   AST_WAKE_IRQ: assert property (wake_req |-> irq) else $error("irq");
   AST_IE_OFF: assert property (wr && !pwdata[4] |=> !wake_req) else $error("wake");
   // Five stable cycles covers the two sync stages and the pin register
   AST_PIN_FOLLOW: assert property ((comp_power_en && compare_out_pin_oe && clk_en && $stable(comp_out_async))[*5]
      |-> compare_out_pin == comp_out_async) else $error("follow");
   AST_RD_OFF: assert property (psel && penable && !pwrite && paddr == 12'h000 && !$past(comp_power_en)
      |-> !prdata[3]) else $error("level");
   cover property ($rose(wake_req));
   cover property (pslverr);
   cover property ($rose(compare_out_pin));
endmodule

bind acc_top acc_top_asserts acc_top_asserts_inst (.clk, .rst_b, .clk_en, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pslverr, .comp_power_en, .reference_select, .comp_out_async, .compare_out_pin,
   .compare_out_pin_oe, .irq, .wake_req);

//--- verif/acc_comp_model.sv
// Behavioural analog comparator at the far side of the block.
// Assumes voltages in millivolts; equal inputs are never applied.
`timescale 1ns/100ps

module acc_comp_model (
   // Controls
   input wire logic power_en,
   input wire logic ref_sel,
   // Voltages
   input wire logic [15:0] pos_mv,
   input wire logic [15:0] neg_mv,
   input wire logic [15:0] ref_mv,
   // Result
   output logic comp_out
);
   logic [15:0] plus_mv;
   assign plus_mv = ref_sel ? ref_mv : pos_mv;
   // Settles off the clock edge so the block must synchronise it
   assign #37 comp_out = power_en && (plus_mv > neg_mv);
endmodule

//--- verif/tb_analog_comparator_control.sv
// Self-checking bench for the comparator control block.
// Assumes acc_top with its bound checker and the comparator model.
`timescale 1ns/100ps

module tb_analog_comparator_control;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [15:0] pos_mv = 16'h0100;
   logic [15:0] neg_mv = 16'h0200;
   logic [15:0] ref_mv = 16'h0300;
   logic [31:0] prdata, q;
   logic pready, pslverr, err, pwr, rsel, cmp, pin, oe, irq, wake;
   int n_mismatch = 0;
   int n_tests = 0;

   always #50 clk = ~clk;

   acc_top acc_top_inst (.clk, .rst_b, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .comp_power_en(pwr), .reference_select(rsel), .comp_out_async(cmp),
      .compare_out_pin(pin), .compare_out_pin_oe(oe), .irq, .wake_req(wake));
   acc_comp_model acc_comp_model_inst (.power_en(pwr), .ref_sel(rsel), .pos_mv, .neg_mv, .ref_mv,
      .comp_out(cmp));

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One idle edge after each transfer so no strobe is driven twice in a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask

   task automatic level(input logic h);
      pos_mv <= h ? 16'h0280 : 16'h0100;
      repeat (5) @(posedge clk);
   endtask

   task automatic t_reset;
      rd("ctrl", 12'h000, 32'h0);
      rd("status", 12'h004, 32'h0);
      rd("mask", 12'h008, 32'h0);
   endtask

   task automatic t_modes;
      logic [7:0] c, f;
      for (int m = 0; m < 4; m++) begin
         c = 8'h90 | 8'(m);
         f = (m % 2) ? 8'h20 : 8'h00;
         apb(1'b1, 12'h000, {24'h0, c});
         level(1'b0);
         apb(1'b1, 12'h000, {24'h0, c | 8'h20});
         level(1'b1);
         rd("rise", 12'h000, {24'h0, c | f | 8'h08});
         chk("irq", 32'(m % 2), 32'(irq));
         apb(1'b1, 12'h000, {24'h0, c});
         rd("keep", 12'h000, {24'h0, c | f | 8'h08});
         apb(1'b1, 12'h000, {24'h0, c | 8'h20});
         level(1'b0);
         rd("fall", 12'h000, {24'h0, c | ((m == 1) ? 8'h00 : 8'h20)});
      end
   endtask

   task automatic t_ref;
      apb(1'b1, 12'h000, 32'hE0);
      level(1'b0);
      rd("ref", 12'h000, 32'hC8);
      chk("ref sel", 32'h1, 32'(rsel));
      apb(1'b1, 12'h000, 32'h04);
      rd("off", 12'h000, 32'h04);
      chk("power", 32'h0, 32'(pwr));
      apb(1'b1, 12'h000, 32'hC4);
      level(1'b0);
      chk("pin on", 32'h1, 32'(pin));
      chk("oe on", 32'h1, 32'(oe));
      apb(1'b1, 12'h000, 32'hC0);
      chk("pin off", 32'h0, 32'(pin));
      chk("oe off", 32'h0, 32'(oe));
   endtask

   task automatic t_irq;
      apb(1'b1, 12'h000, 32'hA1);
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b1, 12'h004, 32'h1);
      level(1'b1);
      chk("wake", 32'h0, 32'(wake));
      chk("irq on", 32'h1, 32'(irq));
      apb(1'b1, 12'h008, 32'h0);
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'b1, 12'h004, 32'h1);
      rd("status", 12'h004, 32'h0);
      rd("flag", 12'h000, 32'hA9);
      apb(1'b1, 12'h00C, 32'hFF);
      chk("err", 32'h1, 32'(err));
      rd("hole", 12'h00C, 32'h0);
   endtask

   // Clock enable low: a write and a level change are both held off
   task automatic t_freeze;
      clk_en <= 1'b0;
      apb(1'b1, 12'h000, 32'h00);
      level(1'b0);
      clk_en <= 1'b1;
      rd("frozen", 12'h000, 32'hA9);
      level(1'b0);
      rd("thawed", 12'h000, 32'hA1);
   endtask

   // Reset in mid-run from a non-zero state
   task automatic t_rerun;
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_modes();
      t_ref();
      t_irq();
      t_freeze();
      t_rerun();
      end_of_test();
   end

   initial begin
      repeat (2000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end
endmodule
